// ---- include/clkgen_pkg.sv ----
`default_nettype none
package clkgen_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 20000;
  localparam int LOCK_TIME_US = 1000;
  localparam int LOCK_CYC = LOCK_TIME_US * CLK_KHZ / 1000;
  localparam int FREE_RUN_KHZ = 1250;
  localparam int FREE_HALF = CLK_KHZ / (2 * FREE_RUN_KHZ);
  localparam int MON_OVF = 16;
  localparam int MAX_HALF = 1023;
  localparam int HALF_TOL = 2;
  // ----------------------------------------------------------------
  // Modes and factors
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_PLL = 3'h0;
  localparam logic [2:0] MODE_PRESC = 3'h1;
  localparam logic [2:0] MODE_DIRECT = 3'h3;
  // Twice the factor: 0.5, 1, 3, 4, 5, 8, 10, 16
  localparam logic [7:0][5:0] FACT2 = {6'h20, 6'h14, 6'h10, 6'h0A,
                                       6'h08, 6'h06, 6'h02, 6'h01};
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_ST = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h0C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h10;
  localparam int CFG_MON_DIS = 0;
  localparam int CFG_FACT_LSB = 1;
  localparam int CFG_IDLE = 4;
  localparam int CFG_PD = 5;
  localparam int CFG_PSEL_LSB = 8;
  localparam int PSEL_W = 2;
  localparam logic [31:0] CFG_CTRL_MASK = 32'h0000003F;
  localparam logic [31:0] CFG_RESET = 32'h00000000;
  localparam int ST_LOCK = 0;
  localparam int ST_DISC = 1;
  localparam int ST_SWITCH = 2;
  localparam int ST_MODE_LSB = 3;
  localparam int ST_PLL_ON = 6;
  localparam int ST_IN_RST = 7;
  localparam int IRQ_UNLOCK = 0;
  localparam int IRQ_MON = 1;
  localparam int IRQ_W = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : clkgen_pkg
`default_nettype wire

// ---- rtl/pll_clock_generator_with_osc_monitor.sv ----
// Function
// [R1] PLL runs unless latched mode is direct drive or prescaler.
// [R2] Locked PLL clock is input clock times selected factor, half duty.
// [R3] Free-running PLL clock is available from power-on without input.
// [R4] PLL locks after stable in-range input for the lock time.
// [R5] Reset pin is held by the system until the PLL has locked.
// [R6] Unlocked at reset release: reference cut, CPU on free-running clock.
// [R7] Loss of lock raises the PLL unlock interrupt flag.
// [R8] On input failure the CPU keeps running from the basic frequency.
// [R9] Prescaler mode: CPU clock is the input clock divided by two.
// [R10] Direct mode: CPU clock follows input, oscillator amplifier bypassed.
// [R11] Prescaler and direct: PLL runs for the monitor unless disabled.
// [R12] Monitor enabled after each reset; software bit disables it.
// [R13] Monitor counts free-running clocks, cleared on each input edge.
// [R14] Overflow at sixteen: switch to PLL clock and flag interrupt.
// [R15] After switchover stay on PLL clock until hardware reset.
// [R16] Monitor disabled: CPU from oscillator input, PLL powered off.
// [R17] Idle stops CPU clock only; power-down stops both clocks.
// [R18] Each peripheral clock selects a binary division of CPU clock.
// [R19] Mode pins are latched at reset release and held till next reset.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module pll_clock_generator_with_osc_monitor #(
  parameter int NP = 4,
  parameter int LOCK_CYCLES = clkgen_pkg::LOCK_CYC,
  parameter int CNT_W = 10
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic nrst,
  // Pins
  input wire logic crystal_input_pin,
  input wire logic reset_input_pin_n,
  input wire logic [2:0] mode_select_port_high,
  // AXI4-Lite write
  input wire logic [clkgen_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [clkgen_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Clock outputs and status
  output logic cpu_clk,
  output logic [NP-1:0] periph_clk,
  output logic pll_power_on,
  output logic osc_amp_bypass,
  output logic irq
);
  // ----------------------------------------------------------------
  // Constants and state
  // ----------------------------------------------------------------
  localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
  localparam int NCO_W = CNT_W + 2;
  localparam int FD_W = $clog2(clkgen_pkg::FREE_HALF) + 1;
  localparam int MW = $clog2(clkgen_pkg::MON_OVF + 1);
  localparam int PD_W = (1 << clkgen_pkg::PSEL_W) - 1;
  localparam int IW = clkgen_pkg::IRQ_W;
  localparam logic [LOCK_W-1:0] LOCK_TOP = LOCK_W'(LOCK_CYCLES);
  localparam logic [FD_W-1:0] FD_TOP = FD_W'(clkgen_pkg::FREE_HALF - 1);
  localparam logic [MW-1:0] MON_TOP = MW'(clkgen_pkg::MON_OVF);
  localparam logic [MW-1:0] MON_LAST = MW'(clkgen_pkg::MON_OVF - 1);
  localparam logic [CNT_W-1:0] HALF_MAX = CNT_W'(clkgen_pkg::MAX_HALF);
  localparam logic [CNT_W-1:0] TOL = CNT_W'(clkgen_pkg::HALF_TOL);
  localparam logic [31:0] PSEL_MASK =
    ((32'h1 << (clkgen_pkg::PSEL_W * NP)) - 32'h1) << clkgen_pkg::CFG_PSEL_LSB;
  localparam logic [31:0] CFG_MASK = clkgen_pkg::CFG_CTRL_MASK | PSEL_MASK;

  typedef struct packed {
    logic [1:0] xtal_s;
    logic xtal_prev;
    logic [1:0] rst_s;
    logic rst_prev;
    logic [5:0] mode_s;
    logic [2:0] mode;
    logic [CNT_W-1:0] half_cnt;
    logic [CNT_W-1:0] meas;
    logic [LOCK_W-1:0] stab;
    logic locked;
    logic disconn;
    logic switched;
    logic [FD_W-1:0] free_div;
    logic free_clk;
    logic [MW-1:0] mon;
    logic [NCO_W-1:0] acc;
    logic nco_clk;
    logic presc_clk;
    logic src;
    logic [PD_W-1:0] pdiv;
    logic cpu_clk;
    logic [NP-1:0] periph_clk;
    logic pll_on;
    logic bypass;
    logic [31:0] cfg;
    logic [IW-1:0] irq_st;
    logic [IW-1:0] irq_en;
    logic irq;
    logic aw_have;
    logic [clkgen_pkg::AXI_AW-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t q;
  state_t n;
  logic in_rst, release_ev, xedge, xrise, free_tick, mon_en, pll_mode;
  logic good, unlock_ev, mon_ev, do_wr;
  logic [CNT_W-1:0] diff;
  logic [NCO_W-1:0] acc_sum, thr;
  logic [31:0] wm, rd;
  logic [IW-1:0] clr, ev;
  logic [clkgen_pkg::PSEL_W-1:0] sel;
  logic [5:0] wofs, rofs;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = q;
    good = 1'b0;
    free_tick = 1'b0;
    unlock_ev = 1'b0;
    mon_ev = 1'b0;
    clr = '0;
    ev = '0;
    sel = '0;
    rd = '0;
    diff = '0;
    acc_sum = '0;
    thr = '0;
    // Synchronisers
    n.xtal_s = {q.xtal_s[0], crystal_input_pin};
    n.xtal_prev = q.xtal_s[1];
    n.rst_s = {q.rst_s[0], reset_input_pin_n};
    n.rst_prev = q.rst_s[1];
    n.mode_s = {q.mode_s[2:0], mode_select_port_high};
    in_rst = !q.rst_s[1];
    release_ev = q.rst_s[1] && !q.rst_prev;
    xedge = q.xtal_s[1] ^ q.xtal_prev;
    xrise = q.xtal_s[1] && !q.xtal_prev;
    // Mode latch
    if (in_rst || release_ev) begin
      n.mode = q.mode_s[5:3]; // [R19]
    end
    pll_mode = (q.mode != clkgen_pkg::MODE_PRESC) &&
               (q.mode != clkgen_pkg::MODE_DIRECT);
    mon_en = !pll_mode && !q.cfg[clkgen_pkg::CFG_MON_DIS]; // [R12]
    n.pll_on = pll_mode || !q.cfg[clkgen_pkg::CFG_MON_DIS]; // [R1] [R11] [R16]
    n.bypass = (q.mode == clkgen_pkg::MODE_DIRECT); // [R10]
    // Free-running oscillator
    if (!q.pll_on) begin
      n.free_div = '0;
      n.free_clk = 1'b0;
    end else if (q.free_div == FD_TOP) begin
      n.free_div = '0;
      n.free_clk = !q.free_clk; // [R3]
      free_tick = !q.free_clk;
    end else begin
      n.free_div = q.free_div + FD_W'(1);
    end
    // Input period measurement and lock, also active under reset
    n.half_cnt = (q.half_cnt == HALF_MAX) ? q.half_cnt :
                 q.half_cnt + CNT_W'(1);
    if (xedge) begin
      n.half_cnt = '0;
      n.meas = q.half_cnt;
      diff = (q.half_cnt >= q.meas) ? q.half_cnt - q.meas :
             q.meas - q.half_cnt;
      good = (diff <= TOL);
    end
    if (!pll_mode || q.disconn || (xedge && !good) ||
        q.half_cnt == HALF_MAX) begin
      n.stab = '0;
    end else if (q.stab != LOCK_TOP) begin
      n.stab = q.stab + LOCK_W'(1); // [R4] [R5]
    end
    n.locked = (n.stab == LOCK_TOP);
    if (in_rst) begin
      n.disconn = 1'b0;
    end else if (release_ev && pll_mode && !q.locked) begin
      n.disconn = 1'b1; // [R6]
    end
    unlock_ev = (q.locked && !n.locked) || (n.disconn && !q.disconn); // [R7]
    // Multiplier
    if (!q.locked) begin
      n.acc = '0;
      n.nco_clk = 1'b0;
    end else begin
      acc_sum = q.acc + NCO_W'(clkgen_pkg::FACT2[
        q.cfg[clkgen_pkg::CFG_FACT_LSB +: 3]]);
      thr = {1'b0, q.meas, 1'b0} + NCO_W'(2); // [R2]
      if (acc_sum >= thr) begin
        n.acc = acc_sum - thr;
        n.nco_clk = !q.nco_clk; // [R2]
      end else begin
        n.acc = acc_sum;
      end
    end
    // Prescaler
    if (xrise) begin
      n.presc_clk = !q.presc_clk; // [R9]
    end
    // Oscillator monitor
    if (!mon_en || xedge || q.switched) begin
      n.mon = '0; // [R13]
    end else if (free_tick && q.mon != MON_TOP) begin
      n.mon = q.mon + MW'(1); // [R13]
    end
    if (in_rst) begin
      n.switched = 1'b0; // [R15]
    end else if (n.mon == MON_TOP) begin
      n.switched = 1'b1; // [R14]
      mon_ev = !q.switched;
    end
    // Clock source selection
    if (q.switched) begin
      n.src = q.free_clk; // [R14] [R15]
    end else if (q.mode == clkgen_pkg::MODE_DIRECT) begin
      n.src = q.xtal_s[1]; // [R10] [R16]
    end else if (q.mode == clkgen_pkg::MODE_PRESC) begin
      n.src = q.presc_clk; // [R9] [R16]
    end else begin
      n.src = q.locked ? q.nco_clk : q.free_clk; // [R6] [R8]
    end
    if (n.src && !q.src) begin
      n.pdiv = q.pdiv + PD_W'(1);
    end
    n.cpu_clk = n.src && !q.cfg[clkgen_pkg::CFG_IDLE] &&
                !q.cfg[clkgen_pkg::CFG_PD]; // [R17]
    for (int k = 0; k < NP; k++) begin
      sel = q.cfg[clkgen_pkg::CFG_PSEL_LSB + clkgen_pkg::PSEL_W * k +:
                  clkgen_pkg::PSEL_W];
      if (q.cfg[clkgen_pkg::CFG_PD]) begin
        n.periph_clk[k] = 1'b0; // [R17]
      end else if (sel == '0) begin
        n.periph_clk[k] = n.src; // [R18]
      end else begin
        n.periph_clk[k] = n.pdiv[sel - clkgen_pkg::PSEL_W'(1)]; // [R18]
      end
    end
    // AXI write channels
    if (s_axi_awvalid && q.awready) begin
      n.aw_have = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_have = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    do_wr = q.aw_have && q.w_have && !q.bvalid;
    wm = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}},
          {8{q.wstrb[0]}}};
    wofs = q.awaddr[7:2];
    if (do_wr) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = clkgen_pkg::RESP_OKAY;
      if (wofs == clkgen_pkg::OFS_CFG[7:2]) begin
        n.cfg = (q.cfg & ~(wm & CFG_MASK)) | (q.wdata & wm & CFG_MASK);
      end else if (wofs == clkgen_pkg::OFS_IRQ_CLR[7:2]) begin
        clr = q.wdata[IW-1:0] & wm[IW-1:0];
      end else if (wofs == clkgen_pkg::OFS_IRQ_EN[7:2]) begin
        n.irq_en = (q.irq_en & ~wm[IW-1:0]) | (q.wdata[IW-1:0] & wm[IW-1:0]);
      end else begin
        n.bresp = clkgen_pkg::RESP_SLVERR;
      end
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;
    // Interrupts, set wins over clear
    ev[clkgen_pkg::IRQ_UNLOCK] = unlock_ev;
    ev[clkgen_pkg::IRQ_MON] = mon_ev; // [R14]
    n.irq_st = (q.irq_st & ~clr) | ev;
    if (in_rst) begin
      n.cfg = clkgen_pkg::CFG_RESET; // [R12]
      n.irq_en = '0;
      n.irq_st = ev;
    end
    n.irq = |(n.irq_st & n.irq_en);
    // AXI read channels
    rofs = s_axi_araddr[7:2];
    rd[clkgen_pkg::ST_LOCK] = q.locked;
    rd[clkgen_pkg::ST_DISC] = q.disconn;
    rd[clkgen_pkg::ST_SWITCH] = q.switched;
    rd[clkgen_pkg::ST_MODE_LSB +: 3] = q.mode;
    rd[clkgen_pkg::ST_PLL_ON] = q.pll_on;
    rd[clkgen_pkg::ST_IN_RST] = in_rst;
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
    if (s_axi_arvalid && q.arready) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = clkgen_pkg::RESP_OKAY;
      if (rofs == clkgen_pkg::OFS_CFG[7:2]) begin
        n.rdata = q.cfg;
      end else if (rofs == clkgen_pkg::OFS_STAT[7:2]) begin
        n.rdata = rd;
      end else if (rofs == clkgen_pkg::OFS_IRQ_ST[7:2]) begin
        n.rdata = 32'(q.irq_st);
      end else if (rofs == clkgen_pkg::OFS_IRQ_CLR[7:2]) begin
        n.rdata = '0;
      end else if (rofs == clkgen_pkg::OFS_IRQ_EN[7:2]) begin
        n.rdata = 32'(q.irq_en);
      end else begin
        n.rdata = '0;
        n.rresp = clkgen_pkg::RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign cpu_clk = q.cpu_clk;
  assign periph_clk = q.periph_clk;
  assign pll_power_on = q.pll_on;
  assign osc_amp_bypass = q.bypass;
  assign irq = q.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_mode_latch: assert property ((q.rst_s[1] && q.rst_prev) |=> // [R19]
    $stable(q.mode)) else $error("mode changed outside reset");
  a_pll_enable: assert property ((q.mode == clkgen_pkg::MODE_PLL) |=> // [R1]
    q.pll_on) else $error("pll off in pll mode");
  a_mon_pll_run: assert property ((q.mode == clkgen_pkg::MODE_PRESC && // [R11]
    !q.cfg[clkgen_pkg::CFG_MON_DIS]) |=> q.pll_on)
    else $error("pll off while monitor enabled");
  a_pll_powered_off: assert property ((q.mode == clkgen_pkg::MODE_DIRECT && // [R16]
    q.cfg[clkgen_pkg::CFG_MON_DIS]) |=> !q.pll_on && !q.switched)
    else $error("pll on while monitor disabled");
  a_mon_clear: assert property (xedge |=> q.mon == '0) // [R13]
    else $error("monitor not cleared on input edge");
  a_ovf_switch: assert property ((q.mon == MON_LAST && free_tick && // [R14]
    !xedge && mon_en && !in_rst && !q.switched) |=>
    q.switched && q.irq_st[clkgen_pkg::IRQ_MON])
    else $error("no switchover at monitor overflow");
  a_switch_hold: assert property ((q.switched && !in_rst) |=> q.switched) // [R15]
    else $error("switchover released without reset");
  a_switch_src: assert property (q.switched |=> q.src == $past(q.free_clk)) // [R14]
    else $error("source not free clock after switchover");
  a_disc_cut: assert property ((release_ev && pll_mode && !q.locked) |=> // [R6]
    q.disconn ##1 !q.locked) else $error("reference not cut");
  a_unlock_flag: assert property ($fell(q.locked) |-> // [R7]
    q.irq_st[clkgen_pkg::IRQ_UNLOCK]) else $error("unlock not flagged");
  a_presc_div: assert property ((q.mode == clkgen_pkg::MODE_PRESC && // [R9]
    !q.switched && xrise) ##1 !q.switched |=> $changed(q.src))
    else $error("prescaler did not toggle");
  a_direct_src: assert property ((q.mode == clkgen_pkg::MODE_DIRECT && // [R10]
    !q.switched) |=> q.src == $past(q.xtal_s[1]) && q.bypass)
    else $error("direct source wrong");
  a_idle_gate: assert property (q.cfg[clkgen_pkg::CFG_IDLE] |=> !q.cpu_clk) // [R17]
    else $error("cpu clock runs in idle");
  a_pd_gate: assert property (q.cfg[clkgen_pkg::CFG_PD] |=> // [R17]
    q.periph_clk == '0 && !q.cpu_clk) else $error("clocks run in power-down");
  c_switchover: cover property ($rose(q.switched));
  c_lock: cover property ($rose(q.locked));
  c_unlock: cover property ($fell(q.locked));
  c_disconn: cover property ($rose(q.disconn));
endmodule : pll_clock_generator_with_osc_monitor
`default_nettype wire

// ---- bench/xtal_source.sv ----
`timescale 1ns/100ps
`default_nettype none
module xtal_source (
  // Clock and control
  input wire logic clk,
  input wire logic run,
  input wire logic [7:0] half,
  // Oscillator output
  output logic crystal_input_pin
);
  // ----------------------------------------------------------------
  // Square wave source
  // ----------------------------------------------------------------
  logic [7:0] cnt_q;
  initial begin
    cnt_q = 8'h00;
    crystal_input_pin = 1'b0;
  end
  // Steady wave while running, stuck level once stopped
  always @(posedge clk) begin
    if (run) begin
      if (cnt_q >= half - 8'h01) begin
        cnt_q <= 8'h00;
        crystal_input_pin <= ~crystal_input_pin;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule : xtal_source
`default_nettype wire

// ---- bench/test_pll_clock_generator_with_osc_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_pll_clock_generator_with_osc_monitor;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, nrst, pin_n, run, awvalid, wvalid, bready, arvalid, rready;
  logic [2:0] straps;
  logic [7:0] awaddr, araddr, half;
  logic [31:0] wdata, d;
  logic [3:0] wstrb;
  wire logic xtal, awready, wready, bvalid, arready, rvalid;
  wire logic cpu_clk, pll_on, bypass, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0] pclk;
  int error_cnt, num_checks, ce, n;
  int pe[4];
  xtal_source osc (.clk(clk), .run(run), .half(half),
    .crystal_input_pin(xtal));
  pll_clock_generator_with_osc_monitor #(.NP(4), .LOCK_CYCLES(50)) uut (
    .clk(clk), .nrst(nrst), .crystal_input_pin(xtal),
    .reset_input_pin_n(pin_n), .mode_select_port_high(straps),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_clk(cpu_clk),
    .periph_clk(pclk), .pll_power_on(pll_on), .osc_amp_bypass(bypass),
    .irq(irq));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic fail(input string nm);
    error_cnt++;
    $display("ERROR %s expected answer seen timeout", nm);
    tally_and_finish();
  endtask : fail
  task automatic check(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic near(input string nm, input int s, e, t);
    check(nm, {31'h0, s >= e - t && s <= e + t}, 32'h1);
  endtask : near
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    int k;
    logic dn;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    dn = 1'b0;
    while (!dn && k < 50) begin
      @(posedge clk);
      k++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        dn = 1'b1;
        bready <= 1'b0;
        check("bresp", {30'h0, bresp}, {30'h0, er});
      end
    end
    if (!dn) fail("write_wait");
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er,
                    output logic [31:0] v);
    int k;
    logic dn;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    dn = 1'b0;
    v = 32'h0;
    while (!dn && k < 50) begin
      @(posedge clk);
      k++;
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        dn = 1'b1;
        v = rdata;
        rready <= 1'b0;
        check("rresp", {30'h0, rresp}, {30'h0, er});
      end
    end
    if (!dn) fail("read_wait");
  endtask : rd
  task automatic st(input string nm, input logic [6:0] e);
    rd(clkgen_pkg::OFS_STAT, clkgen_pkg::RESP_OKAY, d);
    check(nm, {25'h0, d[7:1]}, {25'h0, e});
  endtask : st
  task automatic meas();
    logic cp;
    logic [3:0] pp;
    repeat (20) @(posedge clk);
    ce = 0;
    pe = '{0, 0, 0, 0};
    cp = cpu_clk;
    pp = pclk;
    repeat (400) begin
      @(posedge clk);
      if (cpu_clk === 1'b1 && cp === 1'b0) ce++;
      for (int k = 0; k < 4; k++) begin
        if (pclk[k] === 1'b1 && pp[k] === 1'b0) pe[k]++;
      end
      cp = cpu_clk;
      pp = pclk;
    end
  endtask : meas
  task automatic wait_irq(input int mx);
    n = 0;
    while (irq !== 1'b1 && n < mx) begin
      @(posedge clk);
      n++;
    end
    if (n >= mx) fail("irq_wait");
  endtask : wait_irq
  task automatic pin_rst(input logic [2:0] m, input logic r, input int h);
    pin_n <= 1'b0;
    straps <= m;
    run <= r;
    repeat (h) @(posedge clk);
    pin_n <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : pin_rst
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    fail("run_limit");
  end
  initial begin
    {nrst, pin_n, run, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {straps, awaddr, araddr, wdata, wstrb} = 55'h0;
    half = 8'h0A;
    error_cnt = 0;
    num_checks = 0;
    run = 1'b1;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(clkgen_pkg::OFS_CFG, clkgen_pkg::RESP_OKAY, d);
    check("cfg_reset", d, clkgen_pkg::CFG_RESET);
    rd(clkgen_pkg::OFS_IRQ_CLR, clkgen_pkg::RESP_OKAY, d);
    check("clr_read", d, 32'h0);
    rd(8'h20, clkgen_pkg::RESP_SLVERR, d);
    check("unmapped", d, 32'h0);
    wr(clkgen_pkg::OFS_STAT, 32'h000000FF, clkgen_pkg::RESP_SLVERR);
    n = 0;
    d = 32'h0;
    while (d[clkgen_pkg::ST_LOCK] !== 1'b1 && n < 300) begin
      rd(clkgen_pkg::OFS_STAT, clkgen_pkg::RESP_OKAY, d);
      n++;
    end
    if (n >= 300) fail("lock_wait");
    pin_n <= 1'b1;
    repeat (10) @(posedge clk);
    rd(clkgen_pkg::OFS_STAT, clkgen_pkg::RESP_OKAY, d);
    check("status_pll", {24'h0, d[7:0]}, 32'h00000041);
    for (int i = 0; i < 8; i++) begin
      wr(clkgen_pkg::OFS_CFG, {28'h0, i[2:0], 1'b0}, clkgen_pkg::RESP_OKAY);
      meas();
      n = 10 * int'(clkgen_pkg::FACT2[i]);
      near("cpu_factor", ce, (n > 200) ? 200 : n, 3);
    end
    // Loss of input in PLL mode
    wr(clkgen_pkg::OFS_IRQ_EN, 32'h00000003, clkgen_pkg::RESP_OKAY);
    wr(clkgen_pkg::OFS_CFG, 32'h0, clkgen_pkg::RESP_OKAY);
    run <= 1'b0;
    wait_irq(2000);
    rd(clkgen_pkg::OFS_IRQ_ST, clkgen_pkg::RESP_OKAY, d);
    check("unlock_flag", {31'h0, d[clkgen_pkg::IRQ_UNLOCK]}, 32'h1);
    meas();
    near("free_run", ce, 25, 3);
    run <= 1'b1;
    repeat (300) @(posedge clk);
    wr(clkgen_pkg::OFS_IRQ_CLR, 32'h00000003, clkgen_pkg::RESP_OKAY);
    repeat (3) @(posedge clk);
    check("irq_cleared", {31'h0, irq}, 32'h0);
    // Release while unlocked
    pin_rst(3'h0, 1'b0, 1500);
    st("status_disc", 7'h21);
    rd(clkgen_pkg::OFS_IRQ_ST, clkgen_pkg::RESP_OKAY, d);
    check("disc_flag", {31'h0, d[clkgen_pkg::IRQ_UNLOCK]}, 32'h1);
    check("irq_masked", {31'h0, irq}, 32'h0);
    wr(clkgen_pkg::OFS_IRQ_EN, 32'h00000001, clkgen_pkg::RESP_OKAY);
    repeat (3) @(posedge clk);
    check("irq_enabled", {31'h0, irq}, 32'h1);
    // Prescaler mode and monitor
    pin_rst(3'h1, 1'b1, 20);
    straps <= 3'h3;
    st("status_presc", 7'h24);
    check("presc_bypass", {31'h0, bypass}, 32'h0);
    meas();
    near("presc_rate", ce, 10, 2);
    wr(clkgen_pkg::OFS_IRQ_EN, 32'h00000002, clkgen_pkg::RESP_OKAY);
    run <= 1'b0;
    wait_irq(600);
    check("mon_delay", {31'h0, n >= 200}, 32'h1);
    st("status_switch", 7'h26);
    run <= 1'b1;
    meas();
    near("stay_pll", ce, 25, 3);
    st("still_switch", 7'h26);
    // Direct mode, gating, dividers, monitor off
    pin_rst(3'h3, 1'b1, 20);
    st("status_direct", 7'h2C);
    check("direct_bypass", {31'h0, bypass}, 32'h1);
    wr(clkgen_pkg::OFS_CFG, 32'h0000E400, clkgen_pkg::RESP_OKAY);
    meas();
    near("direct_rate", ce, 20, 2);
    for (int k = 0; k < 4; k++) near("periph_div", pe[k], 20 >> k, 2);
    wr(clkgen_pkg::OFS_CFG, 32'h0000E410, clkgen_pkg::RESP_OKAY);
    meas();
    near("idle_cpu", ce, 0, 0);
    near("idle_periph", pe[0], 20, 2);
    wr(clkgen_pkg::OFS_CFG, 32'h0000E420, clkgen_pkg::RESP_OKAY);
    meas();
    near("pd_cpu", ce, 0, 0);
    near("pd_periph", pe[0], 0, 0);
    wr(clkgen_pkg::OFS_CFG, 32'h00000001, clkgen_pkg::RESP_OKAY);
    repeat (5) @(posedge clk);
    check("pll_off", {31'h0, pll_on}, 32'h0);
    run <= 1'b0;
    repeat (500) @(posedge clk);
    st("no_switch", 7'h0C);
    pin_rst(3'h3, 1'b0, 20);
    rd(clkgen_pkg::OFS_CFG, clkgen_pkg::RESP_OKAY, d);
    check("mon_reenabled", d, 32'h0);
    check("pll_back_on", {31'h0, pll_on}, 32'h1);
    tally_and_finish();
  end
endmodule : test_pll_clock_generator_with_osc_monitor
`default_nettype wire
